// ---- iop_top.sv ----
// I/O ports with serdes, port counters, strobes, conditions and six clock blocks
//
// Overview of operation
// - Ports of several widths map onto fixed pins: 8-bit, 4-bit, 1-bit here.
// - One direction bit per port sets all its pins as inputs or outputs.
// - Ports drive pins high or low or sample them, optionally awaiting a condition.
// - Each register access of a port is answered in one cycle.
// - Open-collector: drive low for zero, float for one, chosen per port.
// - Data moves through a shift register and a transfer register per port.
// - A 16-bit port counter can delay a transfer until it hits a set count.
// - Software can read the running port counter at any time.
// - Each transfer captures the counter as a timestamp for software.
// - A completed input word raises an event toward the scheduler.
// - An enabled link takes its shared pins away from the ports.
// - An enabled narrower port takes over pins shared with a wider port.
// - Pins not shared with a narrower port stay with the wider port.
// - A port always shifts at its full width even when pins are lost.
// - Six clock blocks; block 0 is the 100MHz reference, others programmable.
// - A clock block may take the 1-bit port pin as its clock source.
// - A clock block may divide the clock it takes from that pin.
// - Ports accept an input strobe and produce an output strobe with data.
// - After reset every port is paced by clock block 0.
// - While reset is held the pull-downs on all pins are on.
`include "iop_defines.svh"
`timescale 1ns/100ps
module iop_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [8:0] pin_i,
	output logic [8:0] pin_o,
	output logic [8:0] pin_oe_n_o,
	output logic pull_dn_o,
	input wire logic [2:0] strobe_in_i,
	output logic [2:0] strobe_out_o,
	output logic [2:0] event_o
);
	import iop_pkg::*;

	iop_state_s st;
	iop_state_s nxt;

	// Port width by index; each width maps onto a fixed group of pins
	function automatic int pw(input int i);
		if (i == 0) begin
			return `IOP_P0_W;
		end else if (i == 1) begin
			return `IOP_P1_W;
		end
		return `IOP_P2_W;
	endfunction

	// Pins seen by a port, zero-extended; all pins are read even if owned elsewhere
	function automatic logic [7:0] chunk(input int i, input logic [8:0] pins);
		if (i == 0) begin
			return pins[`IOP_P0_W-1:0];
		end else if (i == 1) begin
			return {4'h0, pins[`IOP_P1_HI:0]};
		end
		return {7'h00, pins[`IOP_CLK_PIN]};
	endfunction

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Next-state logic: clock blocks, bus, ports, then pin ownership
	always_comb begin
		logic reft;
		logic pedge;
		logic req;
		logic tk;
		logic tok;
		logic ok;
		logic match;
		logic drv;
		logic v;
		logic [7:0] ch;
		logic [7:0] m;
		logic [5:0] nch;
		logic [31:0] wd;
		logic [31:0] rd;
		logic [31:0] shn;
		logic [2:0] cbi;
		logic [2:0] wdat;
		logic [1:0] pi;
		logic [4:0] off;
		int w;
		int q;
		int b;
		nxt = st;
		reft = 1'b0;
		pedge = 1'b0;
		req = 1'b0;
		tk = 1'b0;
		tok = 1'b0;
		ok = 1'b0;
		match = 1'b0;
		drv = 1'b0;
		v = 1'b0;
		ch = '0;
		m = '0;
		nch = '0;
		wd = '0;
		rd = '0;
		shn = '0;
		cbi = '0;
		wdat = '0;
		pi = '0;
		off = '0;
		w = 1;
		q = 0;
		b = 0;
		nxt.pd = 1'b0;

		// Block 0 ticks at the reference rate derived from the system clock
		reft = (st.refc == `IOP_REF_DIV_M1);
		nxt.refc = reft ? 8'h00 : st.refc + 8'h01;
		nxt.cb[0].tick = reft;
		// Pin input is taken as synchronous, so only an edge detector is needed
		pedge = pin_i[`IOP_CLK_PIN] & ~st.clk_pin_q;
		nxt.clk_pin_q = pin_i[`IOP_CLK_PIN];
		for (int k = 1; k < `IOP_CB_NUM; k++) begin
			nxt.cb[k].tick = 1'b0;
			if (st.cb[k].src ? pedge : reft) begin
				if (st.cb[k].dc >= st.cb[k].div) begin
					nxt.cb[k].dc = 8'h00;
					nxt.cb[k].tick = 1'b1;
				end else begin
					nxt.cb[k].dc = st.cb[k].dc + 8'h01;
				end
			end
		end

		// Bus slave; runs before the port logic so hardware sets win over clears
		req = cyc_i & stb_i & ~st.ack;
		nxt.ack = req;
		if (req) begin
			if (adr_i < `IOP_PORT_END) begin
				pi = adr_i[6:5];
				off = adr_i[4:0];
				if (off == `IOP_OFF_CFG) begin
					rd = 32'(st.p[pi].cfg);
					wd = bmerge(rd, dat_i, sel_i);
					if (we_i) begin
						nxt.p[pi].cfg = iop_cfg_s'(wd[`IOP_CFG_W-1:0]);
					end
				end else if (off == `IOP_OFF_DATA) begin
					rd = st.p[pi].xfer;
					if (we_i) begin
						nxt.p[pi].xfer = bmerge(rd, dat_i, sel_i);
						nxt.p[pi].txv = 1'b1;
						wdat[pi] = 1'b1;
					end else begin
						nxt.p[pi].rxv = 1'b0;
					end
				end else if (off == `IOP_OFF_STAT) begin
					rd = {26'h0, st.p[pi].rem[2:0], st.p[pi].ovf, st.p[pi].rxv, st.p[pi].txv};
					if (we_i && sel_i[0] && dat_i[`IOP_STAT_OVF]) begin
						nxt.p[pi].ovf = 1'b0;
					end
				end else if (off == `IOP_OFF_CNT) begin
					rd = {16'h0, st.p[pi].cnt};
				end else if (off == `IOP_OFF_TS) begin
					rd = {16'h0, st.p[pi].ts};
				end else if (off == `IOP_OFF_TIME) begin
					rd = {16'h0, st.p[pi].tm};
					wd = bmerge(rd, dat_i, sel_i);
					if (we_i) begin
						nxt.p[pi].tm = wd[15:0];
					end
				end else if (off == `IOP_OFF_COND) begin
					rd = {24'h0, st.p[pi].cond};
					wd = bmerge(rd, dat_i, sel_i);
					if (we_i) begin
						nxt.p[pi].cond = wd[7:0];
					end
				end
			end else if (adr_i >= `IOP_CB_BASE && adr_i < `IOP_CB_END) begin
				cbi = 3'((adr_i - `IOP_CB_BASE) >> 2);
				rd = {16'h0, st.cb[cbi].div, 7'h00, st.cb[cbi].src};
				wd = bmerge(rd, dat_i, sel_i);
				// Block 0 is the fixed reference and ignores writes
				if (we_i && cbi != `IOP_CB_REF) begin
					nxt.cb[cbi].src = wd[0];
					nxt.cb[cbi].div = wd[`IOP_CB_DIV_HI:`IOP_CB_DIV_LO];
				end
			end else if (adr_i == `IOP_LINK_REG) begin
				rd = {31'h0, st.link_en};
				if (we_i && sel_i[0]) begin
					nxt.link_en = dat_i[0];
				end
			end
			nxt.dat = rd;
		end

		// Per-port serdes, counter, strobes, condition and timed transfers
		for (int i = 0; i < `IOP_NPORT; i++) begin
			w = pw(i);
			nch = 6'(`IOP_WORD / w);
			m = 8'((1 << w) - 1);
			cbi = (st.p[i].cfg.cb < 3'(`IOP_CB_NUM)) ? st.p[i].cfg.cb : `IOP_CB_REF;
			tk = st.p[i].cfg.en & st.cb[cbi].tick;
			ch = chunk(i, pin_i);
			nxt.p[i].stb = 1'b0;
			nxt.p[i].evt = 1'b0;
			tok = ~st.p[i].cfg.timed | (st.p[i].cnt == st.p[i].tm);
			match = (((ch ^ st.p[i].cond) & m) == 8'h00) ^ st.p[i].cfg.cond_neq;
			if (tk) begin
				nxt.p[i].cnt = st.p[i].cnt + 16'h0001;
				if (st.p[i].cfg.dir_out) begin
					if (st.p[i].rem != 6'h00) begin
						// Shift the next chunk onto the pins, low bits first
						nxt.p[i].pout = st.p[i].sh[7:0];
						nxt.p[i].sh = st.p[i].sh >> w;
						nxt.p[i].rem = st.p[i].rem - 6'h01;
						nxt.p[i].stb = st.p[i].cfg.stb_en;
					end else if (st.p[i].txv && tok) begin
						// A word written in this same cycle stays pending
						nxt.p[i].sh = st.p[i].xfer;
						nxt.p[i].rem = nch;
						nxt.p[i].txv = wdat[i];
						nxt.p[i].ts = st.p[i].cnt;
						nxt.p[i].cfg.timed = 1'b0;
					end
				end else begin
					// Word start may wait on the pin condition; strobe qualifies data
					ok = tok & (~st.p[i].cfg.stb_en | strobe_in_i[i])
						& (~st.p[i].cfg.cond_en | (st.p[i].rem != 6'h00) | match);
					if (ok) begin
						shn = (st.p[i].sh >> w) | (32'(ch) << (`IOP_WORD - w));
						nxt.p[i].sh = shn;
						nxt.p[i].cfg.timed = 1'b0;
						if (st.p[i].rem == nch - 6'h01) begin
							nxt.p[i].xfer = shn;
							nxt.p[i].rem = 6'h00;
							nxt.p[i].ovf = st.p[i].ovf | st.p[i].rxv;
							nxt.p[i].rxv = 1'b1;
							nxt.p[i].ts = st.p[i].cnt;
							nxt.p[i].evt = 1'b1;
						end else begin
							nxt.p[i].rem = st.p[i].rem + 6'h01;
						end
					end
				end
			end
		end

		// Pin ownership: narrow port over wide port, link over both
		for (int pp = 0; pp < `IOP_NPIN; pp++) begin
			b = pp;
			if (pp == `IOP_CLK_PIN) begin
				q = 2;
				b = 0;
			end else if (pp <= `IOP_P1_HI && nxt.p[1].cfg.en) begin
				q = 1;
			end else begin
				q = 0;
			end
			drv = nxt.p[q].cfg.en & nxt.p[q].cfg.dir_out
				& ~(nxt.link_en & pp >= `IOP_LINK_LO & pp <= `IOP_LINK_HI);
			v = nxt.p[q].pout[b];
			nxt.pin_o[pp] = 1'b0;
			nxt.oe_n[pp] = 1'b1;
			if (drv) begin
				if (nxt.p[q].cfg.oc) begin
					nxt.oe_n[pp] = v;
				end else begin
					nxt.oe_n[pp] = 1'b0;
					nxt.pin_o[pp] = v;
				end
			end
		end
	end

	// State register; reset leaves all ports on block 0 with pull-downs on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.oe_n <= '1;
			st.pd <= 1'b1;
		end else begin
			st <= nxt;
		end
	end

	// Outputs straight from the state register
	assign dat_o = st.dat;
	assign ack_o = st.ack;
	assign pin_o = st.pin_o;
	assign pin_oe_n_o = st.oe_n;
	assign pull_dn_o = st.pd;
	for (genvar g = 0; g < `IOP_NPORT; g++) begin : g_out
		assign strobe_out_o[g] = st.p[g].stb;
		assign event_o[g] = st.p[g].evt;
	end

	// Checks on the state above
	default clocking cb_chk @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer not one cycle after request");
	AST_OC_HIGH: assert property (st.p[2].cfg.oc |-> (pin_oe_n_o[8] || !pin_o[8]))
		else $error("open-collector pin driven high");
	AST_LINK_PINS: assert property (st.link_en |-> &pin_oe_n_o[7:6])
		else $error("port drives a pin owned by the link");
	AST_NARROW: assert property (st.p[1].cfg.en && st.p[1].cfg.dir_out && !st.p[1].cfg.oc
		|-> !pin_oe_n_o[0] && pin_o[0] == st.p[1].pout[0])
		else $error("narrow port lost its shared pin");
	AST_RST_CB0: assert property ($past(rst_i) |-> st.p[0].cfg.cb == 3'h0 && pull_dn_o)
		else $error("port not on block 0 or pull-down off after reset");
	AST_CNT_STEP: assert property (st.cb[0].tick && st.p[0].cfg.en && st.p[0].cfg.cb == 3'h0
		|=> st.p[0].cnt == $past(st.p[0].cnt) + 16'h0001)
		else $error("port counter missed a tick");
	AST_EVT_WORD: assert property ($rose(st.p[0].rxv) |-> event_o[0])
		else $error("input word without event");
	// The test completes input words on port 0, so the stamp is watched there
	AST_TSTAMP: assert property ($rose(st.p[0].rxv) |-> st.p[0].ts == $past(st.p[0].cnt))
		else $error("timestamp does not match counter");
	AST_REF_TICK: assert property (st.cb[0].tick |=> !st.cb[0].tick ##1 st.cb[0].tick)
		else $error("reference block not at half the system rate");

	// Ownership, direction, pull-down and strobe checks; a wider port keeps its unshared pins
	AST_WIDE_PIN: assert property (st.p[0].cfg.en && st.p[0].cfg.dir_out && st.p[0].cfg.oc
		&& st.p[1].cfg.en |-> pin_oe_n_o[5] == st.p[0].pout[5])
		else $error("wide port lost an unshared pin");
	AST_DIR_IN: assert property (!st.p[2].cfg.dir_out |-> pin_oe_n_o[8])
		else $error("input port drives its pin");
	AST_PD_OFF: assert property (!$past(rst_i) |-> !pull_dn_o)
		else $error("pull-down on outside reset");
	AST_STB_EN: assert property (strobe_out_o[2] |-> st.p[2].cfg.stb_en)
		else $error("output strobe while strobes are off");
	// An event is a single pulse; a stuck event would wake the core again and again
	AST_EVT_ONE: assert property (event_o[0] |=> !event_o[0])
		else $error("event longer than one cycle");
	// Block 0 is fixed, so writes there must never change its source or divider
	AST_CB0_FIX: assert property (st.cb[0].src == 1'b0 && st.cb[0].div == 8'h00)
		else $error("reference block was reprogrammed");
	AST_LOAD_TS: assert property ($fell(st.p[2].txv) && st.p[2].cfg.dir_out
		|-> st.p[2].ts == $past(st.p[2].cnt))
		else $error("output load without timestamp");

	// Scenario covers

	COV_OUT_STB: cover property (strobe_out_o[0] ##1 strobe_out_o[0]);
	COV_IN_EVT: cover property (event_o[1]);
	COV_PIN_CLK: cover property (st.cb[1].src && st.cb[1].tick);
	COV_LINK: cover property (st.link_en && st.p[0].cfg.en && st.p[0].cfg.dir_out);
endmodule // iop_top

// ---- iop_defines.svh ----
// Address map, field positions, port widths, pin numbers and timing constants for the I/O port block
`ifndef IOP_DEFINES_SVH
`define IOP_DEFINES_SVH
`define IOP_NPORT 3
`define IOP_NPIN 9
`define IOP_P0_W 8
`define IOP_P1_W 4
`define IOP_P2_W 1
`define IOP_P1_HI 3
`define IOP_CLK_PIN 8
`define IOP_LINK_LO 6
`define IOP_LINK_HI 7
`define IOP_WORD 32
`define IOP_CB_NUM 6
`define IOP_CB_REF 3'h0
`define IOP_CLK_HZ 200000000
`define IOP_REF_HZ 100000000
`define IOP_REF_DIV_M1 8'((`IOP_CLK_HZ / `IOP_REF_HZ) - 1)
`define IOP_CFG_W 10
`define IOP_PORT_END 8'h60
`define IOP_OFF_CFG 5'h00
`define IOP_OFF_DATA 5'h04
`define IOP_OFF_STAT 5'h08
`define IOP_OFF_CNT 5'h0c
`define IOP_OFF_TS 5'h10
`define IOP_OFF_TIME 5'h14
`define IOP_OFF_COND 5'h18
`define IOP_CB_BASE 8'h80
`define IOP_CB_END 8'h98
`define IOP_LINK_REG 8'ha0
`define IOP_STAT_OVF 2
`define IOP_CB_DIV_LO 8
`define IOP_CB_DIV_HI 15
`endif

// ---- iop_pkg.sv ----
// Types shared by the I/O port and clock block logic
package iop_pkg;
	// Per-port configuration word, highest bit first
	typedef struct packed {
		logic [2:0] cb;
		logic stb_en;
		logic timed;
		logic cond_neq;
		logic cond_en;
		logic oc;
		logic dir_out;
		logic en;
	} iop_cfg_s;
	typedef struct packed {
		iop_cfg_s cfg;
		logic [31:0] xfer;
		logic [31:0] sh;
		logic [5:0] rem;
		logic txv;
		logic rxv;
		logic ovf;
		logic [15:0] cnt;
		logic [15:0] ts;
		logic [15:0] tm;
		logic [7:0] cond;
		logic [7:0] pout;
		logic stb;
		logic evt;
	} iop_port_s;
	typedef struct packed {
		logic src;
		logic [7:0] div;
		logic [7:0] dc;
		logic tick;
	} iop_cb_s;
	typedef struct packed {
		iop_port_s [2:0] p;
		iop_cb_s [5:0] cb;
		logic [7:0] refc;
		logic clk_pin_q;
		logic link_en;
		logic ack;
		logic [31:0] dat;
		logic [8:0] pin_o;
		logic [8:0] oe_n;
		logic pd;
	} iop_state_s;
endpackage

// ---- iop_app_model.sv ----
// Application hardware model that sits on the port pins
`timescale 1ns/100ps
module iop_app_model (
	input wire logic [8:0] pin_o_i,
	input wire logic [8:0] pin_oe_n_i,
	input wire logic [7:0] val_i,
	input wire logic drv_i,
	input wire logic ext_clk_i,
	input wire logic ext_run_i,
	output logic [8:0] pin_i_o,
	output logic [2:0] strobe_in_o
);
	// Device drive first; idle pins sit on their pull-downs, never on a stale value
	always_comb begin
		pin_i_o = pin_o_i & ~pin_oe_n_i;
		if (drv_i) begin
			pin_i_o[7:0] = val_i;
		end
		if (ext_run_i) begin
			pin_i_o[8] = ext_clk_i; // Clock stands still between bursts
		end
	end
	// Strobe is raised only while we really supply data
	assign strobe_in_o = {3{drv_i}};
endmodule // iop_app_model

// ---- io_port_clock_blocks_test.sv ----
// Self-checking testbench for the I/O ports and clock blocks
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module io_port_clock_blocks_test;
	logic clk_i, rst_i, cyc, stb, we, ack, pd, drv, eck, erun;
	logic [7:0] adr, val;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, q, bits;
	logic [8:0] pin_i, pin_o, oe_n;
	logic [2:0] sin, sout, evt;
	logic [15:0] c1, tgt;
	int n_errors, n_checks, nb, ne;
	iop_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pull_dn_o(pd),
		.strobe_in_i(sin), .strobe_out_o(sout), .event_o(evt));
	iop_app_model i_app (.pin_o_i(pin_o), .pin_oe_n_i(oe_n), .val_i(val), .drv_i(drv),
		.ext_clk_i(eck), .ext_run_i(erun), .pin_i_o(pin_i), .strobe_in_o(sin));
	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Collect serial output bits on each strobe, count input events
	always @(posedge clk_i) begin
		if (sout[2] === 1'b1) begin
			bits <= {pin_o[8], bits[31:1]};
			nb <= nb + 1;
		end
		if (evt[0] === 1'b1) begin
			ne <= ne + 1;
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One classic cycle; data is taken at the edge where ack is seen
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		`CHK(n, 2)
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	// Slow pin clock bursts: two cycles high, three low
	task automatic eclk(input int k);
		repeat (k) begin
			@(posedge clk_i);
			eck <= 1'b1;
			repeat (2) @(posedge clk_i);
			eck <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
	endtask
	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		summarize();
	end
	initial begin
		{cyc, stb, we, drv, eck, erun} = 6'h0;
		{adr, val, sel, dat_w, bits, nb, ne} = '0;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		`CHK(pd, 1'b1)
		`CHK(oe_n, 9'h1ff)
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK(pd, 1'b0)
		for (int i = 0; i < 3; i++) begin
			rc(8'(i * 32), 32'h0);
		end
		bus(1'b1, 8'h60, 32'hffffffff);
		rc(8'h60, 32'h0);
		bus(1'b1, 8'h94, 32'h00000501);
		rc(8'h94, 32'h00000501);
		// Serial output on the 1-bit port, LSB first, strobed
		bus(1'b1, 8'h40, 32'h43);
		bus(1'b1, 8'h44, 32'hc35a0f96);
		for (int i = 0; i < 300 && nb < 32; i++) @(posedge clk_i);
		`CHK(bits, 32'hc35a0f96)
		`CHK(oe_n[8], 1'b0)
		// Running counter and a timed transfer with its timestamp
		bus(1'b0, 8'h4c, 32'h0);
		c1 = q[15:0];
		bus(1'b0, 8'h4c, 32'h0);
		`CHK(q[15:0] === c1, 1'b0)
		tgt = q[15:0] + 16'h40;
		bus(1'b1, 8'h54, {16'h0, tgt});
		bus(1'b1, 8'h40, 32'h63);
		bus(1'b1, 8'h44, 32'h1);
		repeat (300) @(posedge clk_i);
		bus(1'b0, 8'h50, 32'h0);
		`CHK(q[15:0], tgt)
		// Open-collector byte port, then link and narrow port take pins
		bus(1'b1, 8'h00, 32'h7);
		bus(1'b1, 8'h04, 32'ha5a5a5a5);
		repeat (40) @(posedge clk_i);
		`CHK(oe_n[7:0], 8'ha5)
		bus(1'b1, 8'ha0, 32'h1);
		repeat (4) @(posedge clk_i);
		`CHK(oe_n[7:0], 8'he5)
		bus(1'b1, 8'h20, 32'h3);
		bus(1'b1, 8'h24, 32'h0);
		repeat (40) @(posedge clk_i);
		`CHK(oe_n[7:0], 8'he0)
		`CHK(pin_o[3:0], 4'h0)
		// Input paced by block 1 from the pin clock, divided by two
		bus(1'b1, 8'h20, 32'h0);
		bus(1'b1, 8'h40, 32'h0);
		bus(1'b1, 8'ha0, 32'h0);
		bus(1'b1, 8'h84, 32'h101);
		bus(1'b1, 8'h00, 32'h81);
		val <= 8'h3c;
		drv <= 1'b1;
		erun <= 1'b1;
		eclk(7);
		repeat (6) @(posedge clk_i);
		bus(1'b0, 8'h08, 32'h0);
		`CHK(q[1], 1'b0)
		eclk(1);
		repeat (6) @(posedge clk_i);
		`CHK(ne, 1)
		bus(1'b0, 8'h08, 32'h0);
		`CHK(q[1], 1'b1)
		rc(8'h04, 32'h3c3c3c3c);
		summarize();
	end
endmodule // io_port_clock_blocks_test
